// >>> core/exposure_seq_regs.sv
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`include "exposure_seq_defines.svh"
module exposure_seq_regs
  import exposure_seq_pkg::*;
(
  // clock and reset
  input  wire logic           i_mclk,
  input  wire logic           i_nrst,
  // apb slave
  input  wire logic           i_psel,
  input  wire logic           i_penable,
  input  wire logic           i_pwrite,
  input  wire logic [11:0]    i_paddr,
  input  wire logic [31:0]    i_pwdata,
  output logic [31:0]         o_prdata,
  output logic                o_pready,
  output logic                o_pslverr,
  // exposure loop status
  input  wire aec_status_type i_aec,
  input  wire logic           i_stats_update,
  // sequencer controls and interrupt
  output seq_ctrl_type        o_seq_ctrl,
  output logic                o_irq
);

  state_type r;
  state_type next_r;
  logic [7:0]  idx;
  logic [15:0] rdata;
  logic        mapped;
  logic [2:0]  events;

  assign idx = i_paddr[9:2];

  // read mux; reserved bits and the reserved word read zero, except delay bits 7:0, which read back as written
  always_comb begin
    rdata  = 16'h0000;
    mapped = 1'b1;
    unique case (idx)
      `IDX_COUNT_LOW:   rdata = i_aec.pixel_count[15:0];
      `IDX_COUNT_HIGH:  rdata = {13'h0, i_aec.pixel_count[18:16]};
      `IDX_MEAN_LOCK:   rdata = {3'h0, i_aec.locked, 2'h0, i_aec.average};
      `IDX_EXPOSURE:    rdata = i_aec.exposure;
      `IDX_GAIN:        rdata = {i_aec.digital_gain, i_aec.analog_step_two,
                                 i_aec.analog_step_one};
      `IDX_RSVD_STATUS: rdata = 16'h0000;
      `IDX_MODE:        rdata = r.mode;
      `IDX_DELAY:       rdata = r.delay;
      `IDX_IRQ_STATUS:  rdata = {13'h0, r.irq_status};
      `IDX_IRQ_ENABLE:  rdata = {13'h0, r.irq_enable};
      `IDX_IRQ_CLEAR:   rdata = 16'h0000;
      default:          mapped = 1'b0;
    endcase
  end

  // events: lock gained, lock lost, new statistics
  assign events = {i_stats_update & ~r.prev_update,
                   ~i_aec.locked & r.prev_locked,
                   i_aec.locked & ~r.prev_locked};

  // next state: bus handshake, writable registers, sticky interrupts
  always_comb begin
    logic wr;
    wr = 1'b0;
    next_r             = r;
    next_r.pready      = 1'b0;
    next_r.pslverr     = 1'b0;
    next_r.prev_locked = i_aec.locked;
    next_r.prev_update = i_stats_update;
    unique case (r.state)
      ST_IDLE: begin
        if (i_psel && !i_penable) begin
          next_r.state = ST_SETUP;
        end
      end
      ST_SETUP: begin
        // answer registered: pready rises in the second access cycle
        next_r.state   = ST_ACCESS;
        next_r.pready  = 1'b1;
        next_r.pslverr = ~mapped;
        next_r.prdata  = i_pwrite ? 32'h0000_0000 : {16'h0000, rdata};
      end
      ST_ACCESS: begin
        // only a real access phase may write; an abandoned setup falls away
        wr           = i_psel & i_penable & i_pwrite & mapped;
        next_r.state = ST_IDLE;
      end
      default: next_r.state = ST_IDLE;
    endcase
    // status registers have no write path, so writes there fall away
    if (wr && idx == `IDX_MODE) begin
      next_r.mode = i_pwdata[15:0] & `MODE_WMASK;
    end
    if (wr && idx == `IDX_DELAY) begin
      next_r.delay = i_pwdata[15:0];
    end
    if (wr && idx == `IDX_IRQ_ENABLE) begin
      next_r.irq_enable = i_pwdata[2:0];
    end
    // a new event wins over a clear in the same cycle
    if (wr && idx == `IDX_IRQ_CLEAR) begin
      next_r.irq_status = r.irq_status & ~i_pwdata[2:0];
    end
    next_r.irq_status = next_r.irq_status | events;
    next_r.irq        = |(next_r.irq_status & next_r.irq_enable);
    // decode mode word into sequencer controls
    next_r.ctrl.run       = next_r.mode[`MODE_RUN_BIT];
    next_r.ctrl.rolling   = next_r.mode[`MODE_ROLLING_BIT];
    // triggered and slave only have meaning under global shutter
    next_r.ctrl.triggered = next_r.mode[`MODE_TRIG_BIT] & ~next_r.mode[`MODE_ROLLING_BIT];
    next_r.ctrl.slave     = next_r.mode[`MODE_SLAVE_BIT] & ~next_r.mode[`MODE_ROLLING_BIT];
    next_r.ctrl.delay_en  = next_r.mode[`MODE_DELAY_BIT];
    next_r.ctrl.delay_len = next_r.delay[`DELAY_FIELD_LSB +: 8];
    next_r.ctrl.subsample = next_r.mode[`MODE_SUBSAMP_BIT];
    next_r.ctrl.binning   = next_r.mode[`MODE_BINNING_BIT];
  end

  // single state register
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      r             <= '0;
      r.state       <= ST_IDLE;
      r.mode        <= `MODE_RESET;
      r.delay       <= `DELAY_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign o_prdata   = r.prdata;
  assign o_pready   = r.pready;
  assign o_pslverr  = r.pslverr;
  assign o_seq_ctrl = r.ctrl;
  assign o_irq      = r.irq;

endmodule

// >>> core/exposure_seq_defines.svh
`ifndef EXPOSURE_SEQ_DEFINES_SVH
`define EXPOSURE_SEQ_DEFINES_SVH
// Behaviour
// - the sampled pixel count is 19 bits, its low sixteen bits read in bits 15:0 of the low count register.
// - count bits 18:16 read in bits 2:0 of the high count register.
// - the average status register shows the lock flag in bit 12 and the 10-bit average in bits 9:0.
// - the gain status word shows stage one in 1:0, stage two in 3:2 and the 5.7 digital gain in 15:4.
// - sequencer stays idle while mode bit 0 is 0 and runs while it is 1.
// - mode bit 1 selects global shutter at 0 and rolling shutter at 1.
// - mode bit 4 selects triggered capture, and only while global shutter is chosen.
// - mode bit 6 inserts the readout delay between row overhead end and readout start.
// - mode bit 7 selects subsampled readout.
// - mode bit 8 selects binned readout.
// - the readout delay is the 8-bit value in bits 15:8 of the delay register.

// register indices; byte address is four times the index
`define IDX_COUNT_LOW      8'hB8
`define IDX_COUNT_HIGH     8'hB9
`define IDX_MEAN_LOCK      8'hBA
`define IDX_EXPOSURE       8'hBB
`define IDX_GAIN           8'hBC
`define IDX_RSVD_STATUS    8'hBD
`define IDX_MODE           8'hC0
`define IDX_DELAY          8'hC1
`define IDX_IRQ_STATUS     8'hD0
`define IDX_IRQ_ENABLE     8'hD1
`define IDX_IRQ_CLEAR      8'hD2

// mode word fields
`define MODE_RUN_BIT       0
`define MODE_ROLLING_BIT   1
`define MODE_TRIG_BIT      4
`define MODE_SLAVE_BIT     5
`define MODE_DELAY_BIT     6
`define MODE_SUBSAMP_BIT   7
`define MODE_BINNING_BIT   8
`define MODE_WMASK         16'h01F3
`define MODE_RESET         16'h0000
`define DELAY_RESET        16'h0000
`define DELAY_FIELD_LSB    8

// status fields
`define LOCK_BIT           12
`define IRQ_BITS           3
`define IRQ_LOCK_GAINED    0
`define IRQ_LOCK_LOST      1
`define IRQ_STATS_UPDATE   2
`endif

// >>> core/exposure_seq_pkg.sv
package exposure_seq_pkg;
  // live exposure-loop results from the statistics engine
  typedef struct packed {
    logic [18:0] pixel_count;
    logic [9:0]  average;
    logic        locked;
    logic [15:0] exposure;
    logic [1:0]  analog_step_one;
    logic [1:0]  analog_step_two;
    logic [11:0] digital_gain;
  } aec_status_type;

  // decoded sequencer controls
  typedef struct packed {
    logic       run;
    logic       rolling;
    logic       triggered;
    logic       slave;
    logic       delay_en;
    logic [7:0] delay_len;
    logic       subsample;
    logic       binning;
  } seq_ctrl_type;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_SETUP  = 3'b010,
    ST_ACCESS = 3'b100
  } bus_state_type;

  typedef struct packed {
    bus_state_type state;
    logic [15:0]   mode;
    logic [15:0]   delay;
    logic [2:0]    irq_status;
    logic [2:0]    irq_enable;
    logic          prev_locked;
    logic          prev_update;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    logic          irq;
    seq_ctrl_type  ctrl;
  } state_type;
endpackage

// >>> verif/exposure_seq_sva.sv
`timescale 1ns/1ps
`include "exposure_seq_defines.svh"
module exposure_seq_sva
  import exposure_seq_pkg::*;
(
  input wire logic           i_mclk,
  input wire logic           i_nrst,
  input wire logic           i_psel,
  input wire logic           i_penable,
  input wire logic           i_pwrite,
  input wire logic [11:0]    i_paddr,
  input wire logic [31:0]    i_pwdata,
  input wire logic [31:0]    o_prdata,
  input wire logic           o_pready,
  input wire logic           o_pslverr,
  input wire aec_status_type i_aec,
  input wire logic           i_stats_update,
  input wire seq_ctrl_type   o_seq_ctrl,
  input wire logic           o_irq
);
  logic       acc;
  logic [7:0] idx;
  // completed access and its word index
  assign acc = i_psel && i_penable && o_pready;
  assign idx = i_paddr[9:2];
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  sequence mode_wr;
    acc && i_pwrite && idx == `IDX_MODE;
  endsequence
  sequence rd_at(logic [7:0] a);
    acc && !i_pwrite && idx == a;
  endsequence
  // one wait state: ready is low in the first access cycle and high in the second
  a_ready_after_setup: assert property (i_psel && !i_penable |=> !o_pready ##1 o_pready)
    else $error("no ready after setup");
  a_err_with_ready: assert property (o_pslverr |-> o_pready) else $error("error without ready");
  a_run_follows: assert property (mode_wr |=> o_seq_ctrl.run == $past(i_pwdata[0]))
    else $error("run bit mismatch");
  a_shutter_select: assert property (mode_wr |=> o_seq_ctrl.rolling == $past(i_pwdata[1]))
    else $error("shutter bit mismatch");
  a_global_only: assert property (o_seq_ctrl.rolling |-> !o_seq_ctrl.triggered)
    else $error("trigger while rolling");
  a_sub_bin: assert property (mode_wr |=> {o_seq_ctrl.subsample, o_seq_ctrl.binning} ==
    $past({i_pwdata[7], i_pwdata[8]})) else $error("readout mode mismatch");
  a_delay_len: assert property (acc && i_pwrite && idx == `IDX_DELAY |=>
    o_seq_ctrl.delay_len == $past(i_pwdata[15:8])) else $error("delay length mismatch");
  a_count_low: assert property (rd_at(`IDX_COUNT_LOW) |->
    o_prdata == {16'h0000, $past(i_aec.pixel_count[15:0])}) else $error("count low mismatch");
  a_lock_word: assert property (rd_at(`IDX_MEAN_LOCK) |-> o_prdata ==
    {19'h00000, $past(i_aec.locked), 2'h0, $past(i_aec.average)}) else $error("lock word mismatch");
  a_count_high: assert property (rd_at(`IDX_COUNT_HIGH) |->
    o_prdata == {29'h0, $past(i_aec.pixel_count[18:16])}) else $error("count high mismatch");
  a_gain_word: assert property (rd_at(`IDX_GAIN) |-> o_prdata ==
    {16'h0000, $past(i_aec.digital_gain), $past(i_aec.analog_step_two), $past(i_aec.analog_step_one)})
    else $error("gain word mismatch");
  a_status_ro: assert property (acc && i_pwrite && idx >= `IDX_COUNT_LOW && idx <= `IDX_RSVD_STATUS |->
    !o_pslverr ##1 $stable(o_seq_ctrl)) else $error("status write had an effect");
endmodule

bind exposure_seq_regs exposure_seq_sva u_sva (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .i_aec(i_aec), .i_stats_update(i_stats_update),
  .o_seq_ctrl(o_seq_ctrl), .o_irq(o_irq));

// >>> verif/exposure_status_and_sequencer_config_bench.sv
`timescale 1ns/1ps
`include "exposure_seq_defines.svh"
module exposure_status_and_sequencer_config_bench
  import exposure_seq_pkg::*;
();
  logic           i_mclk = 1'b0, i_nrst = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic           i_stats_update = 1'b0, o_pready, o_pslverr, o_irq, rerr;
  logic [11:0]    i_paddr = 12'h000;
  logic [31:0]    i_pwdata = 32'h0, o_prdata, rdat;
  logic [31:0]    exp_st [6] = '{32'h0000A5A5, 32'h5, 32'h12CB, 32'hBEEF, 32'hABC9, 32'h0};
  aec_status_type i_aec = '0;
  seq_ctrl_type   o_seq_ctrl;
  int             err_count = 0, samples_checked = 0;
  // free-running system clock
  always #5 i_mclk = ~i_mclk;
  exposure_seq_regs uut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_aec(i_aec), .i_stats_update(i_stats_update), .o_seq_ctrl(o_seq_ctrl), .o_irq(o_irq));
  task summarize;
    $display("mismatches %0d of %0d checks", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; an idle edge after it keeps drivers from clashing
  task xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= {2'b00, idx, 2'b00};
    i_pwdata <= wd;
    @(posedge i_mclk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      summarize();
    end
    rdat = o_prdata;
    rerr = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_mclk);
  endtask
  // main sequence; the irq level is given two edges to register
  initial begin
    repeat (16) @(posedge i_mclk);
    i_nrst <= 1'b1;
    @(posedge i_mclk);
    xfer(0, `IDX_MODE, 0); chk(rdat, 32'h0);
    i_aec <= {19'h5A5A5, 10'h2CB, 1'b1, 16'hBEEF, 2'h1, 2'h2, 12'hABC};
    xfer(1, `IDX_COUNT_LOW, 32'hFFFF); chk(32'(rerr), 32'h0);
    for (int i = 0; i < 6; i++) begin
      xfer(0, 8'(`IDX_COUNT_LOW + i), 0); chk(rdat, exp_st[i]);
    end
    xfer(1, `IDX_MODE, 32'hFFFF); chk(32'(o_seq_ctrl), 32'h6403);
    xfer(0, `IDX_MODE, 0); chk(rdat, 32'h01F3);
    xfer(1, `IDX_DELAY, 32'hAB00);
    xfer(1, `IDX_MODE, 32'h0171); chk(32'(o_seq_ctrl), 32'h5EAD);
    xfer(1, `IDX_MODE, 32'h0080); chk(32'(o_seq_ctrl), 32'h02AE);
    xfer(0, 8'h10, 0); chk({rdat[30:0], rerr}, 32'h1);
    xfer(0, `IDX_IRQ_STATUS, 0); chk(rdat, 32'h1);
    chk(32'(o_irq), 32'h0);
    xfer(1, `IDX_IRQ_ENABLE, 32'h7);
    @(posedge i_mclk); chk(32'(o_irq), 32'h1);
    xfer(1, `IDX_IRQ_CLEAR, 32'h1);
    @(posedge i_mclk); chk(32'(o_irq), 32'h0);
    i_stats_update <= 1'b1;
    repeat (2) @(posedge i_mclk);
    chk(32'(o_irq), 32'h1);
    xfer(0, `IDX_IRQ_STATUS, 0); chk(rdat, 32'h4);
    // lock lost must set its own sticky bit and clear the flag in the average word
    xfer(1, `IDX_IRQ_CLEAR, 32'h7);
    i_aec.locked <= 1'b0;
    xfer(0, `IDX_MEAN_LOCK, 0); chk(rdat, 32'h02CB);
    xfer(0, `IDX_IRQ_STATUS, 0); chk(rdat, 32'h2);
    summarize();
  end
endmodule
